/* pliq_cfg.svh */
`ifndef PLIQ_CFG_SVH
`define PLIQ_CFG_SVH

// register byte offsets
`define PLIQ_OFS_CTRL      12'h000
`define PLIQ_OFS_STATUS    12'h004
`define PLIQ_OFS_ATTACH_LO 12'h008
`define PLIQ_OFS_ATTACH_HI 12'h00C
`define PLIQ_OFS_DISPATCH  12'h010

// control register fields
`define PLIQ_CTRL_EN_BIT   0
`define PLIQ_CTRL_DIS_BIT  1
`define PLIQ_CTRL_RUN_BIT  2

// status register fields
`define PLIQ_ST_OVF_LSB    0
`define PLIQ_ST_GIE_BIT    3
`define PLIQ_ST_BUSY_BIT   4

// queue depths
`define PLIQ_DEPTH_COMM    4
`define PLIQ_DEPTH_IO      16
`define PLIQ_DEPTH_TIMED   8

// reset values
`define PLIQ_ATTACH_RST    34'h0

`endif

/* pliq_pkg.sv */
package pliq_pkg;

    // event numbers are 6 bits wide (0..33)
    typedef logic [5:0] pliq_evt_t;

    // dispatcher states, gray along idle -> run -> return
    typedef enum logic [1:0]
    {
        PLIQ_IDLE = 2'b00,
        PLIQ_RUN  = 2'b01,
        PLIQ_RETN = 2'b11
    } pliq_state_e;

endpackage

/* pliq_group_queue.sv */
`timescale 1ns/1ps

// ---------------------------------------------------------------
// one priority group: in-group ranking of simultaneous events, a
// first-come-first-served queue and a sticky overflow flag
// ---------------------------------------------------------------
module pliq_group_queue
#(
    parameter int NSRC  = 4,
    parameter int DEPTH = 4
)
(
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    // event sources, index is in-group priority
    input  wire logic [NSRC-1:0]      evtPulse,
    input  wire pliq_pkg::pliq_evt_t  evtNum [NSRC],
    // pop side
    input  wire logic                 popReq,
    output      logic                 notEmpty,
    output      pliq_pkg::pliq_evt_t  headEvt,
    // overflow flag handling
    input  wire logic                 ovfClear,
    output      logic                 ovfFlag
);
    import pliq_pkg::*;

    localparam int AW = $clog2(DEPTH);

    pliq_evt_t     mem [DEPTH];
    logic [AW-1:0] rdPtr;
    logic [AW-1:0] wrPtr;
    logic [AW:0]   count;

    // lowest in-group index wins among same-cycle arrivals; the rest
    // wait in the staging bits and follow one per cycle
    logic [NSRC-1:0] pending;
    logic [NSRC-1:0] next_pending;
    logic            pickValid;
    pliq_evt_t       pickEvt;
    logic [NSRC-1:0] pickMask;

    always_comb
    begin
        pickValid = 1'b0;
        pickEvt   = '0;
        pickMask  = '0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (pending[i] | evtPulse[i])
            begin
                pickValid = 1'b1;
                pickEvt   = evtNum[i];
                pickMask  = NSRC'(1) << i;
            end
        end
    end

    wire full    = (count == (AW+1)'(DEPTH));
    wire doPop   = popReq & notEmpty;
    wire doPush  = pickValid & (~full | doPop);
    wire dropEvt = pickValid & full & ~doPop;

    assign notEmpty     = (count != '0);
    assign headEvt      = mem[rdPtr];
    assign next_pending = (pending | evtPulse) & ~(pickValid ? pickMask : '0);

    // staging register keeps same-cycle arrivals so none are lost
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            pending <= '0;
        else
            pending <= next_pending;
    end

    // queue storage and pointers; a full queue takes a push only in a pop cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdPtr <= '0;
            wrPtr <= '0;
            count <= '0;
        end
        else
        begin
            if (doPush)
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + AW'(1);
            if (doPop)
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + AW'(1);
            count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (doPush)
            mem[wrPtr] <= pickEvt;
    end

    // sticky overflow, a loss in the clearing cycle wins
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            ovfFlag <= 1'b0;
        else if (dropEvt)
            ovfFlag <= 1'b1;
        else if (ovfClear)
            ovfFlag <= 1'b0;
    end

endmodule

/* pliq_apb_regs.sv */
`timescale 1ns/1ps
`include "pliq_cfg.svh"

// ---------------------------------------------------------------
// apb slave: control commands, attach table, status readback
// ---------------------------------------------------------------
module pliq_apb_regs
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    // control outputs
    output      logic        cmdEnable,
    output      logic        cmdDisable,
    output      logic        runEntry,
    output      logic [33:0] attached,
    // status inputs
    input  wire logic [2:0]  ovfFlags,
    input  wire logic        gieState,
    input  wire logic        busyState,
    input  wire logic [5:0]  curEvt
);
    import pliq_pkg::*;

    wire access    = psel & penable;
    wire wrAccess  = access & pwrite;
    wire selCtrl   = (paddr == `PLIQ_OFS_CTRL);
    wire selStat   = (paddr == `PLIQ_OFS_STATUS);
    wire selAttLo  = (paddr == `PLIQ_OFS_ATTACH_LO);
    wire selAttHi  = (paddr == `PLIQ_OFS_ATTACH_HI);
    wire selDisp   = (paddr == `PLIQ_OFS_DISPATCH);
    wire mapped    = selCtrl | selStat | selAttLo | selAttHi | selDisp;

    // zero-wait slave; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // command bits are self-clearing pulses
    assign cmdEnable  = wrAccess & selCtrl & pwdata[`PLIQ_CTRL_EN_BIT];
    assign cmdDisable = wrAccess & selCtrl & pwdata[`PLIQ_CTRL_DIS_BIT];
    assign runEntry   = wrAccess & selCtrl & pwdata[`PLIQ_CTRL_RUN_BIT];

    wire [31:0] statWord = {27'h0, busyState, gieState, ovfFlags};
    wire [31:0] rdMux    = selStat  ? statWord :
                           selAttLo ? attached[31:0] :
                           selAttHi ? {30'h0, attached[33:32]} :
                           selDisp  ? {26'h0, curEvt} : 32'h00000000;

    // attach table, one bit per event number
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            attached <= `PLIQ_ATTACH_RST;
        else if (wrAccess & selAttLo)
            attached[31:0] <= pwdata;
        else if (wrAccess & selAttHi)
            attached[33:32] <= pwdata[1:0];
    end

    // read data registered during setup so it is stable in access
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= 32'h00000000;
        else if (psel & ~penable & ~pwrite)
            prdata <= rdMux;
    end

endmodule

/* pliq_interrupt_queue.sv */
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "pliq_cfg.svh"

// Operation
// - comm beats io beats timed
// - oldest first within a group
// - at most one routine in progress
// - running routine is never pre-empted
// - events during a routine are queued
// - queue depths 4 or 8, 16, 8
// - one sticky overflow flag per group
// - flags clear on return to main
// - serial 0 events 8, 9, 23
// - serial 1 events 24, 25, 26
// - pulse outputs events 19, 20
// - edges 0..7, counter 0 event 12
// - counter events 27, 28, 13..15
// - counter events 16..18, 32, 29..31, 33
// - timed events 10, 11, 21, 22
// - disabled still queues, never dispatches
// - run entry starts globally disabled
// - only attached events get dispatched

// ---------------------------------------------------------------
// interrupt priority queue top
// ---------------------------------------------------------------
module pliq_interrupt_queue
#(
    parameter int COMM_DEPTH  = `PLIQ_DEPTH_COMM,
    parameter int IO_DEPTH    = `PLIQ_DEPTH_IO,
    parameter int TIMED_DEPTH = `PLIQ_DEPTH_TIMED
)
(
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    // apb register port
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output      logic [31:0]          prdata,
    output      logic                 pready,
    output      logic                 pslverr,
    // communication events, one-cycle pulses
    input  wire logic                 port0RxChar,
    input  wire logic                 port0TxDone,
    input  wire logic                 port0RxMsg,
    input  wire logic                 port1RxMsg,
    input  wire logic                 port1RxChar,
    input  wire logic                 port1TxDone,
    // i/o events, one-cycle pulses
    input  wire logic [1:0]           pulseTrainOutputDone,
    input  wire logic [3:0]           edgeRise,
    input  wire logic [3:0]           edgeFall,
    input  wire logic [5:0]           highSpeedCounterPreset,
    input  wire logic [5:0]           highSpeedCounterDir,
    input  wire logic [5:0]           highSpeedCounterReset,
    // time-based events, one-cycle pulses
    input  wire logic [1:0]           timedTick,
    input  wire logic                 interruptTimerA,
    input  wire logic                 interruptTimerB,
    // processor core side
    output      logic                 isrStart,
    output      pliq_pkg::pliq_evt_t  isrEvent,
    output      logic                 isrActive,
    input  wire logic                 isrDone,
    // queue overflow flags
    output      logic                 commQueueOverflowFlag,
    output      logic                 ioQueueOverflowFlag,
    output      logic                 timedQueueOverflowFlag
);
    import pliq_pkg::*;

    // ---------------------------------------------------------------
    // event number tables
    // ---------------------------------------------------------------
    pliq_evt_t commNum  [6];
    pliq_evt_t ioNum    [24];
    pliq_evt_t timedNum [4];

    // comm numbers in in-group order
    assign commNum[0] = 6'h08;
    assign commNum[1] = 6'h09;
    assign commNum[2] = 6'h17;
    assign commNum[3] = 6'h18;
    assign commNum[4] = 6'h19;
    assign commNum[5] = 6'h1A;

    // i/o numbers in in-group order, index = priority
    assign ioNum[0]  = 6'h13;
    assign ioNum[1]  = 6'h14;
    assign ioNum[2]  = 6'h00;
    assign ioNum[3]  = 6'h02;
    assign ioNum[4]  = 6'h04;
    assign ioNum[5]  = 6'h06;
    assign ioNum[6]  = 6'h01;
    assign ioNum[7]  = 6'h03;
    assign ioNum[8]  = 6'h05;
    assign ioNum[9]  = 6'h07;
    assign ioNum[10] = 6'h0C;
    assign ioNum[11] = 6'h1B;
    assign ioNum[12] = 6'h1C;
    assign ioNum[13] = 6'h0D;
    assign ioNum[14] = 6'h0E;
    assign ioNum[15] = 6'h0F;
    assign ioNum[16] = 6'h10;
    assign ioNum[17] = 6'h11;
    assign ioNum[18] = 6'h12;
    assign ioNum[19] = 6'h20;
    assign ioNum[20] = 6'h1D;
    assign ioNum[21] = 6'h1E;
    assign ioNum[22] = 6'h1F;
    assign ioNum[23] = 6'h21;

    // timed numbers
    assign timedNum[0] = 6'h0A;
    assign timedNum[1] = 6'h0B;
    assign timedNum[2] = 6'h15;
    assign timedNum[3] = 6'h16;

    // ---------------------------------------------------------------
    // source vectors; unattached sources never enter a queue
    // ---------------------------------------------------------------
    logic [33:0] attached;
    logic [5:0]  commRaw;
    logic [23:0] ioRaw;
    logic [3:0]  timedRaw;
    logic [5:0]  commEvt;
    logic [23:0] ioEvt;
    logic [3:0]  timedEvt;

    assign commRaw  = {port1TxDone, port1RxChar, port1RxMsg,
                       port0RxMsg, port0TxDone, port0RxChar};
    assign ioRaw    = {highSpeedCounterPreset[5], highSpeedCounterReset[4],
                       highSpeedCounterDir[4], highSpeedCounterPreset[4],
                       highSpeedCounterPreset[3], highSpeedCounterReset[2],
                       highSpeedCounterDir[2], highSpeedCounterPreset[2],
                       highSpeedCounterReset[1], highSpeedCounterDir[1],
                       highSpeedCounterPreset[1], highSpeedCounterReset[0],
                       highSpeedCounterDir[0], highSpeedCounterPreset[0],
                       edgeFall, edgeRise, pulseTrainOutputDone};
    assign timedRaw = {interruptTimerB, interruptTimerA, timedTick};

    // gate each source by its attach bit
    generate
        for (genvar c = 0; c < 6; c++)
        begin : g_comm
            assign commEvt[c] = commRaw[c] & attached[commNum[c]];
        end
        for (genvar i = 0; i < 24; i++)
        begin : g_io
            assign ioEvt[i] = ioRaw[i] & attached[ioNum[i]];
        end
        for (genvar t = 0; t < 4; t++)
        begin : g_tim
            assign timedEvt[t] = timedRaw[t] & attached[timedNum[t]];
        end
    endgenerate

    // ---------------------------------------------------------------
    // the three group queues
    // ---------------------------------------------------------------
    logic      commNe;
    logic      ioNe;
    logic      timedNe;
    pliq_evt_t commHead;
    pliq_evt_t ioHead;
    pliq_evt_t timedHead;
    logic      popComm;
    logic      popIo;
    logic      popTimed;
    logic      ovfClear;

    pliq_group_queue #(.NSRC(6), .DEPTH(COMM_DEPTH)) u_comm
    (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .evtPulse (commEvt),
        .evtNum   (commNum),
        .popReq   (popComm),
        .notEmpty (commNe),
        .headEvt  (commHead),
        .ovfClear (ovfClear),
        .ovfFlag  (commQueueOverflowFlag)
    );

    pliq_group_queue #(.NSRC(24), .DEPTH(IO_DEPTH)) u_io
    (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .evtPulse (ioEvt),
        .evtNum   (ioNum),
        .popReq   (popIo),
        .notEmpty (ioNe),
        .headEvt  (ioHead),
        .ovfClear (ovfClear),
        .ovfFlag  (ioQueueOverflowFlag)
    );

    pliq_group_queue #(.NSRC(4), .DEPTH(TIMED_DEPTH)) u_timed
    (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .evtPulse (timedEvt),
        .evtNum   (timedNum),
        .popReq   (popTimed),
        .notEmpty (timedNe),
        .headEvt  (timedHead),
        .ovfClear (ovfClear),
        .ovfFlag  (timedQueueOverflowFlag)
    );

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic cmdEnable;
    logic cmdDisable;
    logic runEntry;
    logic gie;

    pliq_apb_regs u_regs
    (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .cmdEnable  (cmdEnable),
        .cmdDisable (cmdDisable),
        .runEntry   (runEntry),
        .attached   (attached),
        .ovfFlags   ({timedQueueOverflowFlag, ioQueueOverflowFlag,
                      commQueueOverflowFlag}),
        .gieState   (gie),
        .busyState  (isrActive),
        .curEvt     (isrEvent)
    );

    // global enable; run entry forces disabled, enable command wins over disable
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            gie <= 1'b0;
        else if (runEntry)
            gie <= 1'b0;
        else if (cmdEnable)
            gie <= 1'b1;
        else if (cmdDisable)
            gie <= 1'b0;
    end

    // ---------------------------------------------------------------
    // dispatcher
    // ---------------------------------------------------------------
    pliq_state_e state;
    pliq_state_e next_state;

    wire anyReady = commNe | ioNe | timedNe;
    wire launch   = (state == PLIQ_IDLE) & gie & anyReady;

    // fixed group priority picks the queue to pop
    assign popComm  = launch & commNe;
    assign popIo    = launch & ~commNe & ioNe;
    assign popTimed = launch & ~commNe & ~ioNe & timedNe;

    wire pliq_evt_t pickHead = commNe ? commHead : (ioNe ? ioHead : timedHead);

    // flags drop when all queues are empty and control leaves the routine
    assign ovfClear = (state == PLIQ_RETN) & ~anyReady;

    always_comb
    begin
        next_state = state;
        unique case (state)
            PLIQ_IDLE: if (launch) next_state = PLIQ_RUN;
            PLIQ_RUN:  if (isrDone) next_state = PLIQ_RETN;
            PLIQ_RETN: next_state = PLIQ_IDLE;
            default:   next_state = PLIQ_IDLE;
        endcase
    end

    // only the done handshake ends a routine, never a new arrival
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            state <= PLIQ_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            isrStart <= 1'b0;
            isrEvent <= '0;
        end
        else
        begin
            isrStart <= launch;
            if (launch)
                isrEvent <= pickHead;
        end
    end

    assign isrActive = (state == PLIQ_RUN);

endmodule

/* pliq_interrupt_queue_sva.sv */
`timescale 1ns/1ps

// ---------------------------------------------------------------
// dispatcher and overflow flag checks on the top ports
// ---------------------------------------------------------------
module pliq_interrupt_queue_sva
#(
    parameter int COMM_DEPTH  = 4,
    parameter int IO_DEPTH    = 16,
    parameter int TIMED_DEPTH = 8
)
(
    // clock and reset
    input wire logic                clk_sys,
    input wire logic                rst_n,
    // processor core side
    input wire logic                isrStart,
    input wire pliq_pkg::pliq_evt_t isrEvent,
    input wire logic                isrActive,
    input wire logic                isrDone,
    // queue overflow flags
    input wire logic                commQueueOverflowFlag,
    input wire logic                ioQueueOverflowFlag,
    input wire logic                timedQueueOverflowFlag
);
    import pliq_pkg::*;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // return cycle: idle, nothing launched
    sequence s_retn;
        !isrActive && !isrStart;
    endsequence
    sequence s_hold;
        isrActive && $stable(isrEvent);
    endsequence

    property p_start_idle;
        isrStart |-> !$past(isrActive);
    endproperty
    property p_start_pulse;
        isrStart |=> !isrStart;
    endproperty
    property p_start_active;
        isrStart |-> isrActive;
    endproperty
    property p_no_preempt;
        isrActive && !isrDone |=> s_hold;
    endproperty
    property p_return;
        isrActive && isrDone |=> s_retn ##1 !isrStart;
    endproperty
    // flags drop only at the edge ending the return cycle
    property p_comm_sticky;
        commQueueOverflowFlag && !$fell(isrActive) |=> commQueueOverflowFlag;
    endproperty
    property p_io_fall;
        $fell(ioQueueOverflowFlag) |-> $past(isrActive, 2) && !$past(isrActive);
    endproperty
    property p_timed_hold;
        timedQueueOverflowFlag && isrActive |=> timedQueueOverflowFlag;
    endproperty

    a_start_idle: assert property (p_start_idle) else $error("start while busy");
    a_start_pulse: assert property (p_start_pulse) else $error("start too long");
    a_start_active: assert property (p_start_active) else $error("start not active");
    a_no_preempt: assert property (p_no_preempt) else $error("routine changed");
    a_return: assert property (p_return) else $error("bad return cycle");
    a_comm_sticky: assert property (p_comm_sticky) else $error("comm flag lost");
    a_io_fall: assert property (p_io_fall) else $error("io flag fell early");
    a_timed_hold: assert property (p_timed_hold) else $error("timed flag lost");
endmodule

/* pliq_core_model.sv */
`timescale 1ns/1ps

// ---------------------------------------------------------------
// processor core: runs each routine for holdCycles + 1 cycles after it sees the start, then returns
// ---------------------------------------------------------------
module pliq_core_model
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // dispatch side
    input  wire logic       isrStart,
    input  wire logic [7:0] holdCycles,
    input  wire logic [2:0] ovfFlags,
    output      logic       isrDone,
    output      logic [2:0] seenFlags
);
    logic [7:0] cnt;
    logic       busy;

    // done pulses only while a routine runs; flags read inside it
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            isrDone   <= 1'b0;
            busy      <= 1'b0;
            cnt       <= 8'h00;
            seenFlags <= 3'h0;
        end
        else
        begin
            isrDone <= 1'b0;
            if (isrStart)
            begin
                busy <= 1'b1;
                cnt  <= holdCycles;
            end
            else if (busy && cnt == 8'h00)
            begin
                isrDone   <= 1'b1;
                busy      <= 1'b0;
                seenFlags <= ovfFlags;
            end
            else if (busy)
                cnt <= cnt - 8'h01;
        end
    end
endmodule

/* plc_interrupt_priority_queue_tb.sv */
`timescale 1ns/1ps
`include "pliq_cfg.svh"

module plc_interrupt_priority_queue_tb;
    import pliq_pkg::*;

    logic        clk_sys, rst_n, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, isrStart, isrActive, isrDone;
    logic [2:0]  ovf, seenFlags;
    logic [37:0] src;
    logic [7:0]  holdCycles;
    pliq_evt_t   isrEvent;
    int          nErrors, testsRun;
    // event number behind each source bit, 6'h3F for unused bits
    logic [5:0]  expNum [38] = '{6'h08, 6'h09, 6'h17, 6'h18, 6'h19, 6'h1A, 6'h13, 6'h14,
        6'h00, 6'h02, 6'h04, 6'h06, 6'h01, 6'h03, 6'h05, 6'h07, 6'h0C, 6'h0D, 6'h10, 6'h20,
        6'h1D, 6'h21, 6'h1B, 6'h0E, 6'h11, 6'h3F, 6'h1E, 6'h3F, 6'h1C, 6'h0F, 6'h12, 6'h3F,
        6'h1F, 6'h3F, 6'h0A, 6'h0B, 6'h15, 6'h16};

    pliq_interrupt_queue u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port0RxChar(src[0]), .port0TxDone(src[1]),
        .port0RxMsg(src[2]), .port1RxMsg(src[3]), .port1RxChar(src[4]), .port1TxDone(src[5]),
        .pulseTrainOutputDone(src[7:6]), .edgeRise(src[11:8]), .edgeFall(src[15:12]),
        .highSpeedCounterPreset(src[21:16]), .highSpeedCounterDir(src[27:22]),
        .highSpeedCounterReset(src[33:28]), .timedTick(src[35:34]),
        .interruptTimerA(src[36]), .interruptTimerB(src[37]), .isrStart(isrStart),
        .isrEvent(isrEvent), .isrActive(isrActive), .isrDone(isrDone),
        .commQueueOverflowFlag(ovf[2]), .ioQueueOverflowFlag(ovf[1]),
        .timedQueueOverflowFlag(ovf[0]));
    pliq_core_model u_core (.clk_sys(clk_sys), .rst_n(rst_n), .isrStart(isrStart),
        .holdCycles(holdCycles), .ovfFlags(ovf), .isrDone(isrDone), .seenFlags(seenFlags));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task check(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            nErrors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // apb master: request held until pready at an edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata; err = pslverr; psel <= 1'b0; penable <= 1'b0;
    endtask
    task pulse(input int i);
        @(posedge clk_sys); src[i] <= 1'b1;
        @(posedge clk_sys); src[i] <= 1'b0;
    endtask
    task waitStart(input logic [5:0] e);
        do begin @(posedge clk_sys); #1; end while (isrStart !== 1'b1);
        check(isrEvent, e);
    endtask
    // any start in the window fails
    task noStart(input int c);
        logic seen;
        seen = 1'b0;
        repeat (c) begin @(posedge clk_sys); #1; if (isrStart === 1'b1) seen = 1'b1; end
        check(seen, 1'b0);
    endtask
    task fill(input int a, input int b, input int d, input int k);
        repeat (d) pulse(a);
        repeat (3) @(posedge clk_sys); #1;
        check(ovf[k], 1'b0);
        pulse(b);
        repeat (3) @(posedge clk_sys); #1;
        check(ovf[k], 1'b1);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task testReset;
        for (int a = 0; a <= 16; a += 4)
        begin
            apb(1'b0, a[11:0], 32'h0);
            check(rd, 32'h0);
        end
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
    endtask
    task testMap;
        apb(1'b1, `PLIQ_OFS_ATTACH_LO, 32'hFFFF_FFFF);
        apb(1'b1, `PLIQ_OFS_ATTACH_HI, 32'h3);
        apb(1'b0, `PLIQ_OFS_ATTACH_HI, 32'h0);
        check(rd, 32'h3);
        apb(1'b1, `PLIQ_OFS_CTRL, 32'h1);
        for (int i = 0; i < 38; i++)
            if (expNum[i] != 6'h3F)
            begin
                pulse(i);
                waitStart(expNum[i]);
            end
        apb(1'b0, `PLIQ_OFS_DISPATCH, 32'h0);
        check(rd[5:0], 6'h16);
    endtask
    // arrivals during a long routine queue, then go by group and age
    task testOrder;
        @(posedge clk_sys); holdCycles <= 8'h1E;
        pulse(36);
        waitStart(6'h15);
        pulse(8); pulse(16); pulse(3); pulse(0);
        waitStart(6'h18);
        waitStart(6'h08);
        waitStart(6'h00);
        waitStart(6'h0C);
        @(posedge clk_sys); holdCycles <= 8'h01;
    endtask
    task testGate;
        apb(1'b1, `PLIQ_OFS_CTRL, 32'h4);
        apb(1'b0, `PLIQ_OFS_STATUS, 32'h0);
        check(rd[3], 1'b0);
        pulse(6);
        noStart(10);
        apb(1'b1, `PLIQ_OFS_CTRL, 32'h1);
        waitStart(6'h13);
        apb(1'b1, `PLIQ_OFS_ATTACH_LO, 32'hFFF7_FFFF);
        pulse(6);
        noStart(10);
        apb(1'b1, `PLIQ_OFS_ATTACH_LO, 32'hFFFF_FFFF);
    endtask
    task testOverflow;
        apb(1'b1, `PLIQ_OFS_CTRL, 32'h2);
        fill(0, 1, `PLIQ_DEPTH_COMM, 2);
        fill(8, 9, `PLIQ_DEPTH_IO, 1);
        fill(34, 35, `PLIQ_DEPTH_TIMED, 0);
        apb(1'b1, `PLIQ_OFS_CTRL, 32'h1);
        repeat (`PLIQ_DEPTH_COMM) waitStart(6'h08);
        repeat (`PLIQ_DEPTH_IO) waitStart(6'h00);
        repeat (`PLIQ_DEPTH_TIMED) waitStart(6'h0A);
        noStart(20);
        check(seenFlags, 3'h7);
        check(ovf, 3'h0);
    endtask

    task testDone;
        $display("errors %0d checks %0d", nErrors, testsRun);
        if (nErrors == 0 && testsRun > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // clock, reset, main sequence and watchdog
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h0; pwdata = 32'h0; src = 38'h0; holdCycles = 8'h01;
        nErrors = 0; testsRun = 0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        testReset;
        testMap;
        testOrder;
        testGate;
        testOverflow;
        testDone;
    end
    initial
    begin
        #300000;
        nErrors++;
        testDone;
    end
endmodule

bind pliq_interrupt_queue pliq_interrupt_queue_sva #(.COMM_DEPTH(COMM_DEPTH),
    .IO_DEPTH(IO_DEPTH), .TIMED_DEPTH(TIMED_DEPTH)) u_sva (.clk_sys(clk_sys),
    .rst_n(rst_n), .isrStart(isrStart), .isrEvent(isrEvent), .isrActive(isrActive),
    .isrDone(isrDone), .commQueueOverflowFlag(commQueueOverflowFlag),
    .ioQueueOverflowFlag(ioQueueOverflowFlag), .timedQueueOverflowFlag(timedQueueOverflowFlag));
